//--- hdl/pit_target.v
// Page invalidate target register with APB slave and flush decode
`timescale 1ns/1ns
`include "pit_consts.vh"

module pit_target #(
    parameter MAX_GUEST_WIDTH = 48,
    parameter MAX_MASK = 6'd9
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Capability locator
    output reg [9:0] offset_locator_field,
    // Flush request to the caches
    output reg flush_valid,
    output reg [63:12] flush_page,
    output reg [63:12] flush_match_mask,
    output reg [15:0] domain_tag,
    output reg flush_leaf,
    output reg flush_nonleaf,
    input wire flush_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg [1:0] state;
    reg [63:0] target;
    reg [1:0] gran;
    reg [63:12] wmask;
    reg [63:12] amask;
    integer i;

    wire access = psel && penable;
    wire wr = access && pwrite;
    wire busy = state[1];
    wire [5:0] mask_order = target[`PIT_MASK_MSB:`PIT_MASK_LSB];
    wire nonleaf_keep_hint = target[`PIT_HINT_BIT];
    wire go = wr && paddr == `PIT_OFF_CMD_HI && pwdata[`PIT_CMD_GO_BIT] && !busy;

    // ------------------------------------------------------------
    // Match masks: bits kept inside guest width, bits cut by mask
    // ------------------------------------------------------------
    always @* begin
        wmask = {52{1'b0}};
        amask = {52{1'b0}};
        for (i = 12; i < 64; i = i + 1) begin
            wmask[i] = (i < MAX_GUEST_WIDTH); // R5
            amask[i] = (i - 12 >= mask_order); // R8
        end
    end

    // ------------------------------------------------------------
    // APB answer: single wait-free access, all maps answer okay
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= `PIT_RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= `PIT_RST_WORD; // R1
            if (psel && !penable && !pwrite && paddr == `PIT_OFF_STATUS) begin
                prdata <= {29'h0, gran, busy};
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes; frozen while a request is in flight so a late
    // write cannot corrupt it
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            target <= 64'h0;
            offset_locator_field <= 10'h0;
        end else begin
            offset_locator_field <= `PIT_LOCATOR_VAL; // R2
            if (wr && pready && !busy) begin // R12
                if (paddr == `PIT_OFF_TARGET_LO) begin
                    target[31:0] <= pwdata; // R4
                end
                if (paddr == `PIT_OFF_TARGET_HI) begin
                    target[63:32] <= pwdata; // R3
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequencer: issue flush, wait for cache to finish
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            gran <= `PIT_GRAN_ERROR;
            flush_valid <= 1'b0;
            flush_page <= {52{1'b0}};
            flush_match_mask <= {52{1'b0}};
            domain_tag <= 16'h0;
            flush_leaf <= 1'b0;
            flush_nonleaf <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && pready) begin
                        if (mask_order > MAX_MASK) begin
                            gran <= `PIT_GRAN_ERROR; // R11
                        end else begin
                            state <= ST_BUSY;
                            flush_valid <= 1'b1;
                            flush_page <= target[63:12] & wmask & amask; // R3
                            flush_match_mask <= wmask & amask; // R5
                            domain_tag <= pwdata[`PIT_DOM_MSB:`PIT_DOM_LSB]; // R10
                            flush_leaf <= 1'b1; // R7
                            flush_nonleaf <= !nonleaf_keep_hint; // R6
                        end
                    end
                end
                ST_BUSY: begin
                    if (flush_done) begin
                        state <= ST_IDLE; // R12
                        flush_valid <= 1'b0;
                        gran <= `PIT_GRAN_PAGE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- hdl/pit_consts.vh
// Constants for the page invalidate target register block
// Function
// R1: Target register is write only; reads return zero, meaningless to software.
// R2: Register sits on a quadword boundary; its offset is advertised by a locator field.
// R3: Bits 63:12 hold the second-stage input page address to invalidate.
// R4: Software loads address, hint and mask before issuing the page invalidate command.
// R5: Address bits at and above the maximum guest width are ignored when matching.
// R6: Hint 0 flushes matching entries from translation and paging-structure caches.
// R7: Hint 1 may keep non-leaf paging entries but still flushes leaf translations.
// R8: Mask M ignores M low address bits from bit 12, selecting 2^M aligned pages.
// R9: Software uses mask of at least 9 for a 2MB large page.
// R10: Domain tag for the request comes from command register bits 47:32.
// R11: Unsupported mask makes the request ignored with error granularity reported.
// R12: Address, hint and mask stay frozen until the command has been consumed.
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PIT_OFF_TARGET_LO 12'h100
`define PIT_OFF_TARGET_HI 12'h104
`define PIT_OFF_CMD_LO 12'h108
`define PIT_OFF_CMD_HI 12'h10c
`define PIT_OFF_STATUS 12'h110
// Locator value in 16-byte units, as a capability field would report it
`define PIT_LOCATOR_VAL 10'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIT_MASK_LSB 0
`define PIT_MASK_MSB 5
`define PIT_HINT_BIT 6
`define PIT_ADDR_LSB 12
`define PIT_DOM_LSB 0
`define PIT_DOM_MSB 15
`define PIT_CMD_GO_BIT 31
`define PIT_ST_BUSY_BIT 0
`define PIT_ST_GRAN_LSB 1
`define PIT_ST_GRAN_MSB 2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define PIT_RST_WORD 32'h0000_0000
`define PIT_GRAN_ERROR 2'h0
`define PIT_GRAN_PAGE 2'h3

`endif

//--- test/pit_target_props.sv
// Assertion checker for the page invalidate target block
`timescale 1ns/1ns
module pit_target_props #(parameter MAX_GUEST_WIDTH = 48, parameter MAX_MASK = 6'd9) (
    // Block ports
    input wire clk, rst_n, psel, penable, pwrite, pready, pslverr, flush_valid,
    input wire flush_leaf, flush_nonleaf, flush_done,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [9:0] offset_locator_field,
    input wire [63:12] flush_page, flush_match_mask,
    input wire [15:0] domain_tag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Busy writes are dropped, so the shadow only follows idle writes
    wire wr = psel && penable && pready && pwrite && !flush_valid;
    wire go = wr && paddr == 12'h10c && pwdata[31];
    reg [6:0] hm;
    always @(posedge clk) begin
        if (!rst_n) hm <= 7'h00;
        else if (wr && paddr == 12'h100) hm <= pwdata[6:0];
    end
    AST_RD_ZERO: assert property (pready && !pwrite && paddr[11:3] == 9'h020 |-> !prdata)
        else $error("target read");
    AST_LOC: assert property ($past(rst_n) |-> offset_locator_field == 10'h010)
        else $error("locator");
    AST_ALIGN: assert property (flush_valid |-> !(flush_page & ~flush_match_mask))
        else $error("page align");
    AST_WIDTH: assert property (flush_valid |-> !flush_match_mask[63:MAX_GUEST_WIDTH])
        else $error("width");
    AST_LEAF: assert property (flush_valid |-> flush_leaf)
        else $error("leaf");
    AST_HOLD: assert property (flush_valid && !flush_done |=> $stable({flush_page, domain_tag}))
        else $error("hold");
    AST_GO: assert property (go && hm[5:0] <= MAX_MASK |=> flush_valid &&
        flush_nonleaf == !hm[6] && domain_tag == $past(pwdata[15:0])) else $error("start");
    AST_BAD: assert property (go && hm[5:0] > MAX_MASK |=> !flush_valid)
        else $error("bad mask");
    AST_NO_ERR: assert property (pready |-> !pslverr)
        else $error("slave error");
    cover property (go && hm[5:0] <= MAX_MASK);
    cover property (go && hm[5:0] > MAX_MASK);
    cover property (flush_valid && flush_done);
endmodule
bind pit_target pit_target_props #(.MAX_GUEST_WIDTH(MAX_GUEST_WIDTH), .MAX_MASK(MAX_MASK))
    u_props (.*);

//--- test/pit_target_tb_top.sv
// Self-checking bench for the page invalidate target block
`timescale 1ns/1ns
module pit_target_tb_top;
    reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, flush_done = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    wire [31:0] prdata;
    wire pready, fv, leaf, nonleaf;
    wire [9:0] loc;
    wire [63:12] page, fmask;
    wire [15:0] dom;
    integer n_mismatch = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    pit_target u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .offset_locator_field(loc), .flush_valid(fv), .flush_page(page),
        .flush_match_mask(fmask), .domain_tag(dom), .flush_leaf(leaf),
        .flush_nonleaf(nonleaf), .flush_done(flush_done));
    task chk(input [63:0] got, exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Request held until pready is seen at an edge
    task apb(input w, input [11:0] a, input [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1) @(posedge clk);
        rd = prdata;
        {psel, penable} <= 0;
        @(posedge clk);
    endtask
    task s_reset;
        chk(loc, 10'h010);
        apb(0, 12'h100, 0);
        chk(rd, 0);
        apb(0, 12'h1f0, 0);
        chk(rd, 0);
    endtask
    task s_flush(input [5:0] m, input h, input [63:0] a, input [15:0] d);
        reg [63:0] mk;
        mk = ((64'h1 << 48) - 1) & ~((64'h1 << (12 + m)) - 1);
        apb(1, 12'h100, {a[31:12], 5'h00, h, m});
        apb(1, 12'h104, a[63:32]);
        apb(1, 12'h10c, {16'h8000, d});
        @(posedge clk);
        chk(fv, 1);
        chk({page, 12'h000}, a & mk);
        chk({fmask, 12'h000}, mk);
        chk({dom, leaf, nonleaf}, {d, 1'b1, ~h});
        // A write while busy must not disturb the request in flight
        apb(1, 12'h100, 32'h3f);
        chk(page, a[63:12] & mk[63:12]);
        chk(dom, d);
        flush_done <= 1;
        @(posedge clk);
        flush_done <= 0;
        @(posedge clk);
        chk(fv, 0);
        apb(0, 12'h110, 0);
        chk(rd, 32'h6);
    endtask
    task s_bad;
        apb(1, 12'h100, 32'ha);
        apb(1, 12'h10c, 32'h8000_0003);
        @(posedge clk);
        chk(fv, 0);
        apb(0, 12'h110, 0);
        chk(rd, 0);
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        s_reset;
        s_flush(6'd0, 0, 64'hffff_ffff_ffff_f000, 16'h0001);
        s_flush(6'd9, 1, 64'h0000_1234_5678_9000, 16'hbeef);
        s_bad;
        test_done;
    end
endmodule
